// ==== ppfs_top.sv ====
/*
 * Pin function and pull-up select for ports C and D, with an AXI4-Lite
 * register slave holding the two 16-bit mode control registers.
 * Assumes one 200 MHz clock, synchronous active-high reset, pins from outside.
 */
module ppfs_top
	import ppfs_pkg::*;
#(
	parameter int PINS = ppfs_pkg::PPFS_PINS
) (
	input  wire logic            clk_in,
	input  wire logic            rst_in,
	input  wire logic            ce_in,
	input  wire logic [7:0]      s_axi_awaddr_in,
	input  wire logic            s_axi_awvalid_in,
	output logic                 s_axi_awready_out,
	input  wire logic [31:0]     s_axi_wdata_in,
	input  wire logic [3:0]      s_axi_wstrb_in,
	input  wire logic            s_axi_wvalid_in,
	output logic                 s_axi_wready_out,
	output logic [1:0]           s_axi_bresp_out,
	output logic                 s_axi_bvalid_out,
	input  wire logic            s_axi_bready_in,
	input  wire logic [7:0]      s_axi_araddr_in,
	input  wire logic            s_axi_arvalid_in,
	output logic                 s_axi_arready_out,
	output logic [31:0]          s_axi_rdata_out,
	output logic [1:0]           s_axi_rresp_out,
	output logic                 s_axi_rvalid_out,
	input  wire logic            s_axi_rready_in,
	input  wire logic [PINS-1:0] portc_out_data_in,
	input  wire logic [PINS-1:0] portd_out_data_in,
	input  wire logic [PINS-1:0] portc_alt_out_in,
	input  wire logic [PINS-1:0] portd_alt_out_in,
	input  wire logic [PINS-1:0] portc_alt_oe_n_in,
	input  wire logic [PINS-1:0] portd_alt_oe_n_in,
	input  wire logic [PINS-1:0] portc_alt_pu_in,
	input  wire logic [PINS-1:0] portd_alt_pu_in,
	input  wire logic [PINS-1:0] portc_pin_in,
	input  wire logic [PINS-1:0] portd_pin_in,
	output logic [PINS-1:0]      portc_pin_out,
	output logic [PINS-1:0]      portd_pin_out,
	output logic [PINS-1:0]      portc_pin_oe_n_out,
	output logic [PINS-1:0]      portd_pin_oe_n_out,
	output logic [PINS-1:0]      portc_pull_up_out,
	output logic [PINS-1:0]      portd_pull_up_out,
	output logic [PINS-1:0]      portc_gpio_in_out,
	output logic [PINS-1:0]      portd_gpio_in_out,
	output logic [PINS-1:0]      portc_alt_in_out,
	output logic [PINS-1:0]      portd_alt_in_out
);

	localparam int CW = ppfs_pkg::PPFS_CTRL_WIDTH;

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic [15:0] ppfs_merge(input logic [15:0] old_v,
		input logic [31:0] wd, input logic [3:0] strb);
		logic [15:0] r;
		r = old_v;
		if (strb[0]) begin
			r[7:0] = wd[7:0];
		end
		if (strb[1]) begin
			r[15:8] = wd[15:8];
		end
		return r;
	endfunction : ppfs_merge

	// ------------------------------------------------------------
	// Register and bus state
	// ------------------------------------------------------------
	logic [CW-1:0] port_c_pin_mode_ctrl;
	logic [CW-1:0] port_d_pin_mode_ctrl;
	logic [CW-1:0] next_port_c_pin_mode_ctrl;
	logic [CW-1:0] next_port_d_pin_mode_ctrl;
	ppfs_bus_t     wr_state;
	ppfs_bus_t     next_wr_state;
	ppfs_bus_t     rd_state;
	ppfs_bus_t     next_rd_state;
	logic          aw_held;
	logic          next_aw_held;
	logic          w_held;
	logic          next_w_held;
	logic [7:0]    aw_addr;
	logic [7:0]    next_aw_addr;
	logic [31:0]   w_data;
	logic [31:0]   next_w_data;
	logic [3:0]    w_strb;
	logic [3:0]    next_w_strb;
	logic [1:0]    next_bresp;
	logic [31:0]   next_rdata;
	logic [1:0]    next_rresp;

	// ------------------------------------------------------------
	// Bus slave next state
	// ------------------------------------------------------------
	always_comb begin
		next_port_c_pin_mode_ctrl = port_c_pin_mode_ctrl;
		next_port_d_pin_mode_ctrl = port_d_pin_mode_ctrl;
		next_wr_state = wr_state;
		next_rd_state = rd_state;
		next_aw_held  = aw_held;
		next_w_held   = w_held;
		next_aw_addr  = aw_addr;
		next_w_data   = w_data;
		next_w_strb   = w_strb;
		next_bresp    = s_axi_bresp_out;
		next_rdata    = s_axi_rdata_out;
		next_rresp    = s_axi_rresp_out;
		if (wr_state == PPFS_BUS_IDLE) begin
			if (s_axi_awvalid_in && s_axi_awready_out) begin
				next_aw_held = 1'b1;
				next_aw_addr = s_axi_awaddr_in;
			end
			if (s_axi_wvalid_in && s_axi_wready_out) begin
				next_w_held = 1'b1;
				next_w_data = s_axi_wdata_in;
				next_w_strb = s_axi_wstrb_in;
			end
			if (aw_held && w_held) begin
				next_bresp = PPFS_RESP_OKAY;
				if (aw_addr[7:2] == PPFS_OFS_PORT_C[7:2]) begin
					next_port_c_pin_mode_ctrl = ppfs_merge(port_c_pin_mode_ctrl,
						w_data, w_strb);
				end else if (aw_addr[7:2] == PPFS_OFS_PORT_D[7:2]) begin
					next_port_d_pin_mode_ctrl = ppfs_merge(port_d_pin_mode_ctrl,
						w_data, w_strb);
				end else begin
					next_bresp = PPFS_RESP_SLVERR;
				end
				next_aw_held  = 1'b0;
				next_w_held   = 1'b0;
				next_wr_state = PPFS_BUS_RESP;
			end
		end else if (s_axi_bready_in) begin
			next_wr_state = PPFS_BUS_IDLE;
		end
		if (rd_state == PPFS_BUS_IDLE) begin
			if (s_axi_arvalid_in && s_axi_arready_out) begin
				next_rresp = PPFS_RESP_OKAY;
				next_rdata = 32'h0000_0000;
				if (s_axi_araddr_in[7:2] == PPFS_OFS_PORT_C[7:2]) begin
					next_rdata[CW-1:0] = port_c_pin_mode_ctrl;
				end else if (s_axi_araddr_in[7:2] == PPFS_OFS_PORT_D[7:2]) begin
					next_rdata[CW-1:0] = port_d_pin_mode_ctrl;
				end else begin
					next_rresp = PPFS_RESP_SLVERR;
				end
				next_rd_state = PPFS_BUS_RESP;
			end
		end else if (s_axi_rready_in) begin
			next_rd_state = PPFS_BUS_IDLE;
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			port_c_pin_mode_ctrl <= PPFS_CTRL_RESET;
			port_d_pin_mode_ctrl <= PPFS_CTRL_RESET;
			wr_state          <= PPFS_BUS_IDLE;
			rd_state          <= PPFS_BUS_IDLE;
			aw_held           <= 1'b0;
			w_held            <= 1'b0;
			aw_addr           <= 8'h00;
			w_data            <= 32'h0000_0000;
			w_strb            <= 4'h0;
			s_axi_awready_out <= 1'b0;
			s_axi_wready_out  <= 1'b0;
			s_axi_bvalid_out  <= 1'b0;
			s_axi_bresp_out   <= PPFS_RESP_OKAY;
			s_axi_arready_out <= 1'b0;
			s_axi_rvalid_out  <= 1'b0;
			s_axi_rresp_out   <= PPFS_RESP_OKAY;
			s_axi_rdata_out   <= 32'h0000_0000;
		end else if (ce_in) begin
			port_c_pin_mode_ctrl <= next_port_c_pin_mode_ctrl;
			port_d_pin_mode_ctrl <= next_port_d_pin_mode_ctrl;
			wr_state          <= next_wr_state;
			rd_state          <= next_rd_state;
			aw_held           <= next_aw_held;
			w_held            <= next_w_held;
			aw_addr           <= next_aw_addr;
			w_data            <= next_w_data;
			w_strb            <= next_w_strb;
			s_axi_awready_out <= (next_wr_state == PPFS_BUS_IDLE) && !next_aw_held;
			s_axi_wready_out  <= (next_wr_state == PPFS_BUS_IDLE) && !next_w_held;
			s_axi_bvalid_out  <= (next_wr_state == PPFS_BUS_RESP);
			s_axi_bresp_out   <= next_bresp;
			s_axi_arready_out <= (next_rd_state == PPFS_BUS_IDLE);
			s_axi_rvalid_out  <= (next_rd_state == PPFS_BUS_RESP);
			s_axi_rresp_out   <= next_rresp;
			s_axi_rdata_out   <= next_rdata;
		end
	end

	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	logic [PINS-1:0] portc_sync1;
	logic [PINS-1:0] portc_sync2;
	logic [PINS-1:0] portd_sync1;
	logic [PINS-1:0] portd_sync2;

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			portc_sync1 <= '0;
			portc_sync2 <= '0;
			portd_sync1 <= '0;
			portd_sync2 <= '0;
		end else if (ce_in) begin
			portc_sync1 <= portc_pin_in;
			portc_sync2 <= portc_sync1;
			portd_sync1 <= portd_pin_in;
			portd_sync2 <= portd_sync1;
		end
	end

	// ------------------------------------------------------------
	// Pin muxes
	// ------------------------------------------------------------
	logic [PINS-1:0] c_pin;
	logic [PINS-1:0] c_oe_n;
	logic [PINS-1:0] c_pu;
	logic [PINS-1:0] c_gsel;
	logic [PINS-1:0] c_asel;
	logic [PINS-1:0] d_pin;
	logic [PINS-1:0] d_oe_n;
	logic [PINS-1:0] d_pu;
	logic [PINS-1:0] d_gsel;
	logic [PINS-1:0] d_asel;

	ppfs_port_mux #(.PINS(PINS)) u_mux_c (
		.mode_in         (port_c_pin_mode_ctrl),
		.out_data_in     (portc_out_data_in),
		.alt_out_in      (portc_alt_out_in),
		.alt_oe_n_in     (portc_alt_oe_n_in),
		.alt_pu_in       (portc_alt_pu_in),
		.pin_out         (c_pin),
		.pin_oe_n_out    (c_oe_n),
		.pin_pu_out      (c_pu),
		.gpio_in_sel_out (c_gsel),
		.alt_sel_out     (c_asel)
	);

	ppfs_port_mux #(.PINS(PINS)) u_mux_d (
		.mode_in         (port_d_pin_mode_ctrl),
		.out_data_in     (portd_out_data_in),
		.alt_out_in      (portd_alt_out_in),
		.alt_oe_n_in     (portd_alt_oe_n_in),
		.alt_pu_in       (portd_alt_pu_in),
		.pin_out         (d_pin),
		.pin_oe_n_out    (d_oe_n),
		.pin_pu_out      (d_pu),
		.gpio_in_sel_out (d_gsel),
		.alt_sel_out     (d_asel)
	);

	// ------------------------------------------------------------
	// Registered pin outputs
	// ------------------------------------------------------------
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			portc_pin_out      <= '0;
			portd_pin_out      <= '0;
			portc_pin_oe_n_out <= '1;
			portd_pin_oe_n_out <= '1;
			portc_pull_up_out  <= '0;
			portd_pull_up_out  <= '0;
			portc_gpio_in_out  <= '0;
			portd_gpio_in_out  <= '0;
			portc_alt_in_out   <= '0;
			portd_alt_in_out   <= '0;
		end else if (ce_in) begin
			portc_pin_out      <= c_pin;
			portd_pin_out      <= d_pin;
			portc_pin_oe_n_out <= c_oe_n;
			portd_pin_oe_n_out <= d_oe_n;
			portc_pull_up_out  <= c_pu;
			portd_pull_up_out  <= d_pu;
			portc_gpio_in_out  <= portc_sync2 & c_gsel;
			portd_gpio_in_out  <= portd_sync2 & d_gsel;
			portc_alt_in_out   <= portc_sync2 & c_asel;
			portd_alt_in_out   <= portd_sync2 & d_asel;
		end
	end

endmodule : ppfs_top

// ==== ppfs_pkg.sv ====
/*
 * Package for the port pin function select block: offsets, field layout,
 * reset values and the mode encoding.
 * Assumes nothing of its surroundings beyond a SystemVerilog compiler.
 */
package ppfs_pkg;

	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam logic [7:0]  PPFS_OFS_PORT_C   = 8'h00;
	localparam logic [7:0]  PPFS_OFS_PORT_D   = 8'h04;
	localparam logic [15:0] PPFS_CTRL_RESET   = 16'h0000;
	localparam int          PPFS_CTRL_WIDTH   = 16;
	localparam int          PPFS_FIELD_WIDTH  = 2;
	localparam int          PPFS_PINS         = 8;
	localparam logic [1:0]  PPFS_RESP_OKAY    = 2'h0;
	localparam logic [1:0]  PPFS_RESP_SLVERR  = 2'h2;

	// ------------------------------------------------------------
	// Mode encoding
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		PPFS_MODE_ALT     = 2'h0,
		PPFS_MODE_OUT     = 2'h1,
		PPFS_MODE_IN_PU   = 2'h2,
		PPFS_MODE_IN_NOPU = 2'h3
	} ppfs_mode_t;

	// ------------------------------------------------------------
	// Bus slave states
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		PPFS_BUS_IDLE = 2'h0,
		PPFS_BUS_RESP = 2'h1
	} ppfs_bus_t;

endpackage : ppfs_pkg

// ==== ppfs_port_mux.sv ====
/*
 * One 8-pin port: decodes the mode fields into pin drive, enable and pull-up,
 * and selects whether pin levels go to the alternate function or the input data.
 * Assumes pin inputs are already synchronised by the caller.
 */
module ppfs_port_mux
	import ppfs_pkg::*;
#(
	parameter int PINS = 8
) (
	input  wire logic [2*PINS-1:0] mode_in,
	input  wire logic [PINS-1:0]   out_data_in,
	input  wire logic [PINS-1:0]   alt_out_in,
	input  wire logic [PINS-1:0]   alt_oe_n_in,
	input  wire logic [PINS-1:0]   alt_pu_in,
	output logic      [PINS-1:0]   pin_out,
	output logic      [PINS-1:0]   pin_oe_n_out,
	output logic      [PINS-1:0]   pin_pu_out,
	output logic      [PINS-1:0]   gpio_in_sel_out,
	output logic      [PINS-1:0]   alt_sel_out
);

	// ------------------------------------------------------------
	// Per-pin decode
	// ------------------------------------------------------------
	always_comb begin
		for (int i = 0; i < PINS; i++) begin
			pin_out[i]         = 1'b0;
			pin_oe_n_out[i]    = 1'b1;
			pin_pu_out[i]      = 1'b0;
			gpio_in_sel_out[i] = 1'b0;
			alt_sel_out[i]     = 1'b0;
			case (ppfs_mode_t'(mode_in[2*i +: 2]))
				PPFS_MODE_ALT: begin
					pin_out[i]      = alt_out_in[i];
					pin_oe_n_out[i] = alt_oe_n_in[i];
					pin_pu_out[i]   = alt_pu_in[i];
					alt_sel_out[i]  = 1'b1;
				end
				PPFS_MODE_OUT: begin
					pin_out[i]      = out_data_in[i];
					pin_oe_n_out[i] = 1'b0;
				end
				PPFS_MODE_IN_PU: begin
					pin_pu_out[i]      = 1'b1;
					gpio_in_sel_out[i] = 1'b1;
				end
				default: begin
					gpio_in_sel_out[i] = 1'b1;
				end
			endcase
		end
	end

endmodule : ppfs_port_mux

// ==== ppfs_chk.sv ====
/* Checker for ppfs_top: bus handshakes, reset state, pin routing.
 * Assumes binding to ppfs_top and ce_in high while reset is held. */
module ppfs_chk #(
	parameter int PINS = 8
) (
	input wire logic             clk_in, rst_in, ce_in,
	input wire logic             s_axi_awvalid_in, s_axi_awready_out,
	input wire logic             s_axi_wvalid_in, s_axi_wready_out,
	input wire logic             s_axi_bvalid_out, s_axi_bready_in,
	input wire logic             s_axi_arvalid_in, s_axi_arready_out,
	input wire logic             s_axi_rvalid_out, s_axi_rready_in,
	input wire logic [1:0]       s_axi_bresp_out,
	input wire logic [31:0]      s_axi_rdata_out,
	input wire logic [PINS-1:0]  portc_alt_out_in, portc_pin_out, portc_pin_oe_n_out,
	input wire logic [PINS-1:0]  portc_pull_up_out, portd_pin_oe_n_out,
	input wire logic [PINS-1:0]  portc_gpio_in_out, portc_alt_in_out,
	input wire logic [PINS-1:0]  portd_gpio_in_out, portd_alt_in_out
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);
	sequence s_wr_take;
		ce_in && s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out;
	endsequence
	property p_wr_resp; s_wr_take |-> ##2 s_axi_bvalid_out; endproperty
	a_wr_resp: assert property (p_wr_resp) else $error("no write response");
	property p_b_hold; s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out && $stable(s_axi_bresp_out); endproperty
	a_b_hold: assert property (p_b_hold) else $error("bvalid dropped");
	property p_r_hold; s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out && $stable(s_axi_rdata_out); endproperty
	a_r_hold: assert property (p_r_hold) else $error("read data changed");
	property p_rd_lat; ce_in && s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out && !s_axi_arready_out; endproperty
	a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
	property p_ar_block; s_axi_rvalid_out |-> !s_axi_arready_out; endproperty
	a_ar_block: assert property (p_ar_block) else $error("arready during rvalid");
	property p_aw_block; s_axi_bvalid_out |-> !s_axi_awready_out && !s_axi_wready_out; endproperty
	a_aw_block: assert property (p_aw_block) else $error("write ready during bvalid");
	property p_reset;
		$fell(rst_in) && $past(ce_in) |-> !s_axi_bvalid_out && !s_axi_rvalid_out && !s_axi_awready_out
			&& &portc_pin_oe_n_out && &portd_pin_oe_n_out && portc_pull_up_out == '0;
	endproperty
	a_reset: assert property (p_reset) else $error("bad reset state");
	property p_alt_pass;
		$past(ce_in) |-> (~portc_pin_oe_n_out & portc_pull_up_out & (portc_pin_out ^ $past(portc_alt_out_in))) == '0;
	endproperty
	a_alt_pass: assert property (p_alt_pass) else $error("alt drive not passed");
	property p_excl;
		(portc_gpio_in_out & portc_alt_in_out) == '0 && (portd_gpio_in_out & portd_alt_in_out) == '0;
	endproperty
	a_excl: assert property (p_excl) else $error("pin routed twice");
endmodule : ppfs_chk
bind ppfs_top ppfs_chk #(.PINS(PINS)) chk (.*);

// ==== ppfs_pins.sv ====
/* Pin pads: resolves driver, outside source, pull-up; floating pins toggle.
 * Assumes one clock shared with the block. */
module ppfs_pins #(
	parameter int PINS = 8
) (
	input wire logic             clk_in,
	input wire logic [PINS-1:0]  drv_in, oe_n_in, pu_in, ext_in, ext_en_in,
	output logic [PINS-1:0]      lvl_out
);
	logic [PINS-1:0] last = '0;
	always_comb begin
		for (int i = 0; i < PINS; i++) begin
			if (!oe_n_in[i]) lvl_out[i] = drv_in[i];
			else if (ext_en_in[i]) lvl_out[i] = ext_in[i];
			else if (pu_in[i]) lvl_out[i] = 1'b1;
			else lvl_out[i] = !last[i];
		end
	end
	always @(posedge clk_in) last <= lvl_out;
endmodule : ppfs_pins

// ==== ppfs_tb_top.sv ====
/* Testbench for ppfs_top: AXI4-Lite tasks, mode sweeps, pin checks.
 * Assumes the checker is bound from its own file. */
module ppfs_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import ppfs_pkg::*;
	logic        clk_in = 1'b0, rst_in = 1'b1, ce_in = 1'b1;
	logic [7:0]  s_axi_awaddr_in = 8'h00, s_axi_araddr_in = 8'h00;
	logic        s_axi_awvalid_in = 1'b0, s_axi_wvalid_in = 1'b0, s_axi_bready_in = 1'b0;
	logic        s_axi_arvalid_in = 1'b0, s_axi_rready_in = 1'b0;
	logic [31:0] s_axi_wdata_in = 32'h0, s_axi_rdata_out;
	logic [3:0]  s_axi_wstrb_in = 4'h0;
	logic        s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out;
	logic        s_axi_arready_out, s_axi_rvalid_out;
	logic [1:0]  s_axi_bresp_out, s_axi_rresp_out;
	logic [7:0]  portc_out_data_in = 8'h96, portd_out_data_in = 8'h69;
	logic [7:0]  portc_alt_out_in = 8'h3C, portd_alt_out_in = 8'hC3;
	logic [7:0]  portc_alt_oe_n_in = 8'hF0, portd_alt_oe_n_in = 8'h0F;
	logic [7:0]  portc_alt_pu_in = 8'hA5, portd_alt_pu_in = 8'h5A;
	logic [7:0]  portc_pin_in, portd_pin_in, portc_pin_out, portd_pin_out;
	logic [7:0]  portc_pin_oe_n_out, portd_pin_oe_n_out, portc_pull_up_out, portd_pull_up_out;
	logic [7:0]  portc_gpio_in_out, portd_gpio_in_out, portc_alt_in_out, portd_alt_in_out;
	logic [7:0]  ext_c = 8'h55, ext_d = 8'hAA, en_c = 8'hFF, en_d = 8'hFF;
	int          errors = 0, compares = 0;
	int          lag = 0;
	always #2.5 clk_in = ~clk_in;
	ppfs_top #(.PINS(8)) dut (.*);
	ppfs_pins pc (.clk_in, .drv_in(portc_pin_out), .oe_n_in(portc_pin_oe_n_out),
		.pu_in(portc_pull_up_out), .ext_in(ext_c), .ext_en_in(en_c), .lvl_out(portc_pin_in));
	ppfs_pins pd (.clk_in, .drv_in(portd_pin_out), .oe_n_in(portd_pin_oe_n_out),
		.pu_in(portd_pull_up_out), .ext_in(ext_d), .ext_en_in(en_d), .lvl_out(portd_pin_in));
	task automatic conclude;
		$display("errors %0d compares %0d", errors, compares);
		if (errors == 0 && compares > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : conclude
	task automatic cmp(input logic [47:0] got, input logic [47:0] exp, input string what);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : cmp
	task automatic tmo;
		errors++;
		$display("CHECK FAILED %0t bus timeout", $time);
		conclude();
	endtask : tmo
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
		input logic [1:0] r);
		logic ta, tw, tb;
		logic [1:0] g;
		@(posedge clk_in);
		s_axi_awaddr_in <= a;
		s_axi_wdata_in <= d;
		s_axi_wstrb_in <= s;
		s_axi_awvalid_in <= 1'b1;
		s_axi_wvalid_in <= 1'b1;
		s_axi_bready_in <= (lag == 0);
		for (int n = 0; n < 40; n++) begin
			@(negedge clk_in);
			ta = s_axi_awvalid_in & s_axi_awready_out;
			tw = s_axi_wvalid_in & s_axi_wready_out;
			tb = s_axi_bvalid_out & s_axi_bready_in;
			g = s_axi_bresp_out;
			@(posedge clk_in);
			if (ta) s_axi_awvalid_in <= 1'b0;
			if (tw) s_axi_wvalid_in <= 1'b0;
			if (tb === 1'b1) begin
				s_axi_bready_in <= 1'b0;
				cmp(48'(g), 48'(r), "bresp");
				return;
			end else if (n + 1 >= lag) begin
				s_axi_bready_in <= 1'b1;
			end
		end
		tmo();
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
		logic ta, tb;
		logic [33:0] g;
		@(posedge clk_in);
		s_axi_araddr_in <= a;
		s_axi_arvalid_in <= 1'b1;
		s_axi_rready_in <= (lag == 0);
		for (int n = 0; n < 40; n++) begin
			@(negedge clk_in);
			ta = s_axi_arvalid_in & s_axi_arready_out;
			tb = s_axi_rvalid_out & s_axi_rready_in;
			g = {s_axi_rresp_out, s_axi_rdata_out};
			@(posedge clk_in);
			if (ta) s_axi_arvalid_in <= 1'b0;
			if (tb === 1'b1) begin
				s_axi_rready_in <= 1'b0;
				cmp(48'(g), 48'({r, e}), "read resp and data");
				return;
			end else if (n + 1 >= lag) begin
				s_axi_rready_in <= 1'b1;
			end
		end
		tmo();
	endtask : rd
	function automatic logic [39:0] pexp(input logic [15:0] m,
		input logic [7:0] od, ao, aoe, apu, ext);
		logic [39:0] r = '0;
		for (int i = 0; i < 8; i++) begin
			case (m[2*i+:2])
				2'h0: {r[32+i], r[24+i], r[16+i], r[i]} = {ao[i], aoe[i], apu[i], aoe[i] ? ext[i] : ao[i]};
				2'h1: {r[32+i], r[24+i]} = {od[i], 1'b0};
				2'h2: {r[24+i], r[16+i], r[8+i]} = 3'h7;
				default: {r[24+i], r[8+i]} = {1'b1, ext[i]};
			endcase
		end
		return {r[39:32] & ~r[31:24], r[31:0]};
	endfunction : pexp
	task automatic setm(input logic [15:0] mc, input logic [15:0] md);
		logic [39:0] c, d;
		for (int i = 0; i < 8; i++) begin
			en_c[i] <= mc[2*i+:2] != 2'h2;
			en_d[i] <= md[2*i+:2] != 2'h2;
		end
		wr(PPFS_OFS_PORT_C, {16'h0000, mc}, 4'h3, PPFS_RESP_OKAY);
		wr(PPFS_OFS_PORT_D, {16'h0000, md}, 4'h3, PPFS_RESP_OKAY);
		rd(PPFS_OFS_PORT_C, {16'h0000, mc}, PPFS_RESP_OKAY);
		repeat (4) @(posedge clk_in);
		@(negedge clk_in);
		c = pexp(mc, portc_out_data_in, portc_alt_out_in, portc_alt_oe_n_in, portc_alt_pu_in, ext_c);
		d = pexp(md, portd_out_data_in, portd_alt_out_in, portd_alt_oe_n_in, portd_alt_pu_in, ext_d);
		cmp(48'({portc_pin_out & ~portc_pin_oe_n_out, portc_pin_oe_n_out, portc_pull_up_out,
			portc_gpio_in_out, portc_alt_in_out}), 48'(c), "port c pins");
		cmp(48'({portd_pin_out & ~portd_pin_oe_n_out, portd_pin_oe_n_out, portd_pull_up_out,
			portd_gpio_in_out, portd_alt_in_out}), 48'(d), "port d pins");
	endtask : setm
	initial begin
		repeat (5) @(posedge clk_in);
		rst_in <= 1'b0;
		rd(PPFS_OFS_PORT_C, 32'h0, PPFS_RESP_OKAY);
		rd(PPFS_OFS_PORT_D, 32'h0, PPFS_RESP_OKAY);
		$display("test reset done");
		wr(PPFS_OFS_PORT_C, 32'hFFFFA5C3, 4'hF, PPFS_RESP_OKAY);
		rd(PPFS_OFS_PORT_C, 32'h0000A5C3, PPFS_RESP_OKAY);
		wr(PPFS_OFS_PORT_D, 32'h00005A3C, 4'h3, PPFS_RESP_OKAY);
		wr(PPFS_OFS_PORT_C, 32'h00001234, 4'h1, PPFS_RESP_OKAY);
		rd(PPFS_OFS_PORT_C, 32'h0000A534, PPFS_RESP_OKAY);
		lag = 3;
		wr(8'h08, 32'h0000FFFF, 4'h3, PPFS_RESP_SLVERR);
		rd(8'h08, 32'h0, PPFS_RESP_SLVERR);
		lag = 0;
		rd(PPFS_OFS_PORT_D, 32'h00005A3C, PPFS_RESP_OKAY);
		$display("test registers done");
		for (int m = 0; m < 4; m++) setm({8{2'(m)}}, {8{2'(3 - m)}});
		setm(16'h1B1B, 16'hE4E4);
		$display("test modes done");
		conclude();
	end
endmodule : ppfs_tb_top
